// ---- verif/tb_rtccs_top.sv ----
// Self-checking bench for the timekeeper control and status registers.
// Assumes the design constants header and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rtccs_cfg.svh"
module tb_rtccs_top;
import rtccs_pkg::*;
////////////////////////////////////////////////////////////////////////////////
logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [7:0] paddr = 8'h00, yearField = 8'h00;
logic [31:0] pwdata = 32'h0, prdata;
logic pready, pslverr, calendarStopped, hourPlusPulse, hourMinusPulse, hourFormatPm;
logic wakeIrqEnable, alarmIrqEnable, alarmEnable, alarmPin, calibOutPin;
logic kernelTick = 1'b1, oneHzTick = 1'b1, shadowCopied = 1'b0, shadowBypass = 1'b0;
logic shiftLowWritten = 1'b0, shiftDone = 1'b0, calibLowWritten = 1'b0, calibApplied = 1'b0;
logic alarmMatch = 1'b0, calib512Hz = 1'b1, calib1Hz = 1'b0;
logic [2:0] tamperEvent = 3'h0;
int miscompares = 0, samplesChecked = 0, cyc = 0, plusCount = 0, minusCount = 0;
logic [31:0] rd;
logic err;
int t0, v;
localparam logic [7:0] A_CTRL1 = 8'h20, A_EN = 8'h24, A_OUT = 8'h28;
localparam logic [7:0] A_STAT = 8'h30, A_EVT = 8'h34, A_WHI = 8'h50, A_WLO = 8'h54;
localparam int E_SHL = 0, E_SHD = 1, E_CAL = 2, E_CALOK = 3, E_SYNC = 4, E_ALARM = 5;

always #25 clock = ~clock;
always @(posedge clock) begin
	cyc <= cyc + 1;
	plusCount <= plusCount + int'(hourPlusPulse === 1'b1);
	minusCount <= minusCount + int'(hourMinusPulse === 1'b1);
end

rtccs_top rtccs_top_i (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .kernelTick(kernelTick), .oneHzTick(oneHzTick),
	.shadowCopied(shadowCopied), .shadowBypass(shadowBypass), .yearField(yearField),
	.shiftLowWritten(shiftLowWritten), .shiftDone(shiftDone),
	.calibLowWritten(calibLowWritten), .calibApplied(calibApplied), .alarmMatch(alarmMatch),
	.tamperEvent(tamperEvent), .calib512Hz(calib512Hz), .calib1Hz(calib1Hz),
	.calendarStopped(calendarStopped), .hourPlusPulse(hourPlusPulse),
	.hourMinusPulse(hourMinusPulse), .hourFormatPm(hourFormatPm),
	.wakeIrqEnable(wakeIrqEnable), .alarmIrqEnable(alarmIrqEnable),
	.alarmEnable(alarmEnable), .alarmPin(alarmPin), .calibOutPin(calibOutPin));
////////////////////////////////////////////////////////////////////////////////
task automatic print_verdict();
	$display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
	if (miscompares == 0 && samplesChecked > 0) begin
		$display("STATUS OK");
	end else begin
		$display("STATUS NOT OK");
	end
	$finish;
endtask

task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
	samplesChecked++;
	if (got !== exp) begin
		miscompares++;
		$display("[ERR] %s expected %h seen %h", name, exp, got);
	end
endtask

// The request is held until pready is seen high at a rising edge.
// Only the watchdog ends a wait whose answer never comes.
task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
	@(posedge clock);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= wr;
	paddr <= a;
	pwdata <= {24'h0, d};
	@(posedge clock);
	penable <= 1'b1;
	do begin
		@(posedge clock);
	end while (pready !== 1'b1);
	rd = prdata;
	err = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask

task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] exp);
	apb(1'b0, a, 8'h00);
	chk(name, {24'h0, exp & m}, rd & {24'h0, m});
endtask

task automatic pulse(input int k);
	@(posedge clock);
	{alarmMatch, shadowCopied, calibApplied, calibLowWritten, shiftDone,
		shiftLowWritten} <= 6'h01 << k;
	@(posedge clock);
	{alarmMatch, shadowCopied, calibApplied, calibLowWritten, shiftDone,
		shiftLowWritten} <= 6'h00;
	repeat (3) @(posedge clock);
endtask

task automatic waitPin(input logic lvl);
	int n;
	n = 0;
	do begin
		@(posedge clock);
		n++;
	end while (alarmPin !== lvl && n < 400);
	if (n >= 400) chk("alarmPin wait", {31'h0, lvl}, {31'h0, alarmPin});
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (20000) @(posedge clock);
	miscompares++;
	print_verdict();
end

initial begin
	v = $urandom(32'h2c1dfbda);
	repeat (8) @(posedge clock);
	arst_n <= 1'b1;
	repeat (3) @(posedge clock);
	rdchk("enables reset", A_EN, 8'hff, 8'h00);
	rdchk("outputs reset", A_OUT, 8'hff, 8'h00);
	rdchk("events reset", A_EVT, 8'hff, 8'h00);
	apb(1'b0, 8'h3c, 8'h00);
	chk("unmapped error", 32'h1, {31'h0, err});
	chk("unmapped data", 32'h0, rd);
	$display("Test reset and map done");
	// Random enable patterns; reserved bits must read zero.
	for (int i = 0; i < 4; i++) begin
		v = $urandom() & 32'hfa;
		apb(1'b1, A_EN, v[7:0]);
		rdchk("enables rw", A_EN, 8'hff, v[7:0] & 8'h55);
		chk("irq enables", {30'h0, v[6], v[4]}, {30'h0, wakeIrqEnable, alarmIrqEnable});
		chk("alarm enable", 32'h0, {31'h0, alarmEnable});
		v = $urandom() & 32'h7c;
		apb(1'b1, A_OUT, v[7:0]);
		rdchk("outputs rw", A_OUT, 8'hff, v[7:0]);
	end
	$display("Test enables done");
	// Hour format outside setup, then adjust hour in free run.
	apb(1'b1, A_CTRL1, 8'h40);
	repeat (2) @(posedge clock);
	chk("format outside setup", 32'h0, {31'h0, hourFormatPm});
	v = plusCount;
	apb(1'b1, A_OUT, 8'h01);
	repeat (3) @(posedge clock);
	chk("plus pulses", v + 1, plusCount);
	rdchk("plus reads zero", A_OUT, 8'h03, 8'h00);
	v = minusCount;
	apb(1'b1, A_OUT, 8'h02);
	repeat (3) @(posedge clock);
	chk("minus pulses", v + 1, minusCount);
	// Status flags driven by calendar side events.
	pulse(E_SHL);
	rdchk("shift pending", A_STAT, 8'h08, 8'h08);
	apb(1'b1, A_STAT, 8'h00);
	rdchk("shift not writable", A_STAT, 8'h08, 8'h08);
	pulse(E_SHD);
	rdchk("shift done", A_STAT, 8'h08, 8'h00);
	pulse(E_CAL);
	rdchk("recal pending", A_STAT, 8'h02, 8'h02);
	pulse(E_CALOK);
	rdchk("recal done", A_STAT, 8'h02, 8'h00);
	rdchk("calendar unset", A_STAT, 8'h10, 8'h00);
	yearField <= 8'h21;
	repeat (3) @(posedge clock);
	rdchk("calendar set", A_STAT, 8'h10, 8'h10);
	pulse(E_SYNC);
	rdchk("sync set", A_STAT, 8'h20, 8'h20);
	apb(1'b1, A_STAT, 8'h00);
	rdchk("sync cleared", A_STAT, 8'h20, 8'h00);
	shadowBypass <= 1'b1;
	pulse(E_SYNC);
	rdchk("sync bypassed", A_STAT, 8'h20, 8'h00);
	shadowBypass <= 1'b0;
	pulse(E_SYNC);
	// Setup mode: counters stop, acknowledge rises, sync flag drops.
	apb(1'b1, A_STAT, 8'ha0);
	repeat (rtccs_top_i.SETUP_DELAY + 4) @(posedge clock);
	chk("stopped", 32'h1, {31'h0, calendarStopped});
	rdchk("setup ack", A_STAT, 8'he0, 8'hc0);
	apb(1'b1, A_CTRL1, 8'h40);
	repeat (2) @(posedge clock);
	chk("format in setup", 32'h1, {31'h0, hourFormatPm});
	v = plusCount;
	apb(1'b1, A_OUT, 8'h01);
	repeat (3) @(posedge clock);
	chk("plus in setup", v, plusCount);
	apb(1'b1, A_STAT, 8'h00);
	repeat (3) @(posedge clock);
	chk("restarted", 32'h0, {31'h0, calendarStopped});
	rdchk("ack cleared", A_STAT, 8'h40, 8'h00);
	$display("Test status done");
	// Calibration pin for both rates and both source levels.
	for (int r = 0; r < 4; r++) begin
		calib512Hz <= r[0];
		calib1Hz <= ~r[0];
		apb(1'b1, A_OUT, {4'h8, r[1], 3'h0});
		repeat (2) @(posedge clock);
		chk("calib pin", {31'h0, r[1] ? ~r[0] : r[0]}, {31'h0, calibOutPin});
	end
	apb(1'b1, A_OUT, 8'h00);
	repeat (2) @(posedge clock);
	chk("calib off", 32'h0, {31'h0, calibOutPin});
	// Alarm flag, pin routing, polarity and delayed clear.
	apb(1'b1, A_EN, 8'h01);
	rdchk("alarm allowed", A_STAT, 8'h01, 8'h00);
	chk("alarm enable on", 32'h1, {31'h0, alarmEnable});
	pulse(E_ALARM);
	rdchk("alarm flag", A_EVT, 8'h01, 8'h01);
	for (int s = 0; s < 4; s++) begin
		if (s != 2) begin
			apb(1'b1, A_OUT, {1'b0, s[1:0], 5'h00});
			repeat (2) @(posedge clock);
			chk("pin high", {31'h0, s == 1}, {31'h0, alarmPin});
			apb(1'b1, A_OUT, {1'b0, s[1:0], 5'h10});
			repeat (2) @(posedge clock);
			chk("pin low", {31'h0, s != 1}, {31'h0, alarmPin});
		end
	end
	apb(1'b1, A_EVT, 8'hfe);
	repeat (2) @(posedge clock);
	rdchk("alarm cleared", A_EVT, 8'h01, 8'h00);
	apb(1'b1, A_EN, 8'h00);
	repeat (2) @(posedge clock);
	rdchk("alarm allowed", A_STAT, 8'h01, 8'h01);
	// Tamper flags map to bits 5..7 and clear one at a time.
	for (int t = 0; t < 3; t++) begin
		tamperEvent <= 3'h1 << t;
		@(posedge clock);
		tamperEvent <= 3'h0;
		repeat (2) @(posedge clock);
		rdchk("tamper set", A_EVT, 8'he0, 8'h20 << t);
		apb(1'b1, A_EVT, ~(8'h20 << t));
		repeat (3) @(posedge clock);
		rdchk("tamper clear", A_EVT, 8'he0, 8'h00);
	end
	$display("Test pins and events done");
	// Wakeup period for choices 000 to 101, seen through the alarm pin.
	apb(1'b1, A_WHI, 8'h00);
	apb(1'b1, A_WLO, 8'h0f);
	apb(1'b1, A_OUT, 8'h60);
	for (int c = 0; c < 6; c++) begin
		repeat (4) @(posedge clock);
		rdchk("wake allowed", A_STAT, 8'h04, 8'h04);
		apb(1'b1, A_CTRL1, c[7:0]);
		apb(1'b1, A_EN, 8'h04);
		apb(1'b1, A_CTRL1, 8'h03 ^ c[7:0]);
		rdchk("choice guarded", A_CTRL1, 8'h07, c[7:0]);
		rdchk("wake busy", A_STAT, 8'h04, 8'h00);
		waitPin(1'b1);
		t0 = cyc;
		apb(1'b1, A_EVT, 8'hfb);
		waitPin(1'b0);
		waitPin(1'b1);
		chk("wake period", 16 * (c < 4 ? 16 >> c : 1), cyc - t0);
		apb(1'b1, A_EN, 8'h00);
		apb(1'b1, A_EVT, 8'hfb);
	end
	// With choice 11x the extra count keeps the flag away far longer than the plain period.
	apb(1'b1, A_CTRL1, 8'h06);
	apb(1'b1, A_EN, 8'h04);
	repeat (100) @(posedge clock);
	rdchk("wake extra count", A_EVT, 8'h04, 8'h00);
	apb(1'b1, A_EN, 8'h00);
	$display("Test wakeup done");
	print_verdict();
end
endmodule
`default_nettype wire

// ---- verilog/rtccs_cfg.svh ----
// Constants of the timekeeper control and status block: offsets, fields, reset values.
// Assumes a 32-bit APB with byte addresses equal to four times the register index.
// Behaviour
// - Wake clock choice 000..011 divides kernel clock by 16, 8, 4, 2.
// - Choice 10x counts one-second ticks; 11x also adds 0x10000 to the count.
// - Wake clock choice and hour format change only when allowed.
// - Enables register: wake irq bit 6, alarm irq 4, wake timer 2, alarm 0.
// - Calibration pin driven when enabled; rate bit picks 512 Hz or 1 Hz.
// - Alarm pin source: 00 off, 01 alarm flag, 11 wake flag, 10 reserved.
// - Alarm pin high on selected flag, or low when active-low bit set.
// - Daylight saving memo bit is plain software storage.
// - Hour plus and minus one act outside setup mode, read as zero.
// - Setup request stops calendar counters; clearing restarts them.
// - Setup acknowledge set only while in setup mode and updates allowed.
// - Shadow synced sets on copy, clears in setup mode or by writing zero.
// - Calendar was set reports year field nonzero.
// - Shift pending sets on shift low write, clears on completion, not writable.
// - Wake write allowed rises after wake timer disabled, low otherwise.
// - Calibration low write sets recal pending until new settings take effect.
// - Alarm write allowed follows alarm disabled.
// - Tamper flags at bits 7, 6, 5 for inputs 3, 2, 1; cleared writing zero.
// - Wake flag sets when down-counter reaches zero; cleared writing zero.
// - Alarm match flag sets on time and date match; cleared writing zero.
// - Writing zero to an event flag clears it about two cycles later.
// - Wake flag asserts every reload value plus one wake clock periods.
`ifndef RTCCS_CFG_SVH
`define RTCCS_CFG_SVH
`define RTCCS_IDX_CTRL1 8'h08
`define RTCCS_IDX_ENABLES 8'h09
`define RTCCS_IDX_OUTPUTS 8'h0a
`define RTCCS_IDX_STATUS 8'h0c
`define RTCCS_IDX_EVENTS 8'h0d
`define RTCCS_IDX_WAKE_HI 8'h14
`define RTCCS_IDX_WAKE_LO 8'h15
`define RTCCS_BIT_WAKE_IRQ 6
`define RTCCS_BIT_ALARM_IRQ 4
`define RTCCS_BIT_WAKE_ON 2
`define RTCCS_BIT_ALARM_ON 0
`define RTCCS_ENABLES_MASK 8'h55
`define RTCCS_CTRL1_MASK 8'h77
`define RTCCS_BIT_FMT 6
`define RTCCS_BIT_INIT 7
`define RTCCS_BIT_SYNC 5
`define RTCCS_BIT_WAKE_EVT 2
`define RTCCS_BIT_ALARM_EVT 0
`define RTCCS_EVENTS_MASK 8'he5
`define RTCCS_RESET_BYTE 8'h00
`define RTCCS_WAKE_RESET 16'hffff
`define RTCCS_CLEAR_DELAY 2
`define RTCCS_EXTRA_COUNT 17'h10000
`endif

// ---- verilog/rtccs_pkg.sv ----
// Types of the timekeeper control and status block.
// Assumes the constants header is compiled alongside.
package rtccs_pkg;
	typedef enum logic [1:0] {RTCCS_PIN_OFF, RTCCS_PIN_ALARM, RTCCS_PIN_RSVD, RTCCS_PIN_WAKE} rtccs_pin_src_t;
	typedef enum {RTCCS_RUN, RTCCS_SETUP_WAIT, RTCCS_SETUP} rtccs_mode_t;
endpackage

// ---- verilog/rtccs_top.sv ----
// Control and status registers of the timekeeper with wakeup timer and pin routing.
// Assumes calendar, prescalers, shift, calibration and tamper logic sit outside on this clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtccs_cfg.svh"
module rtccs_top #(
	parameter int SETUP_DELAY = 2
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic arst_n,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Kernel clock enable and calendar side signals.
	input wire logic kernelTick,
	input wire logic oneHzTick,
	input wire logic shadowCopied,
	input wire logic shadowBypass,
	input wire logic [7:0] yearField,
	input wire logic shiftLowWritten,
	input wire logic shiftDone,
	input wire logic calibLowWritten,
	input wire logic calibApplied,
	input wire logic alarmMatch,
	input wire logic [2:0] tamperEvent,
	input wire logic calib512Hz,
	input wire logic calib1Hz,
	// Outputs to calendar and pins.
	output logic calendarStopped,
	output logic hourPlusPulse,
	output logic hourMinusPulse,
	output logic hourFormatPm,
	output logic wakeIrqEnable,
	output logic alarmIrqEnable,
	output logic alarmEnable,
	output logic alarmPin,
	output logic calibOutPin
);
	import rtccs_pkg::*;
	initial begin
		if (SETUP_DELAY < 1 || SETUP_DELAY > 255) $error("SETUP_DELAY out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	logic rstMeta_reg, rst_n_reg;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rst_n_reg <= rstMeta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Every access completes in its first access cycle: pready is registered from the setup phase (psel and not penable).
	logic wrEn, rdEn;
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		hit = (a[1:0] == 2'b00) && (a[7:2] == idx[5:0]);
	endfunction

	logic [7:0] ctrl1_reg, enables_reg, outputs_reg, events_reg;
	logic [15:0] wakeReload_reg;
	logic initReq_reg, setupAck_reg, synced_reg, shiftPend_reg, recalPend_reg;
	logic wakeWriteOk_reg, alarmWriteOk_reg;
	rtccs_mode_t mode_reg;
	logic [7:0] setupCnt_reg;
	logic [7:0] clrMask_reg;
	logic [7:0] wd;
	assign wd = pwdata[7:0];

	// first control register; clock choice and hour format bits guarded
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl1_reg <= `RTCCS_RESET_BYTE;
		end else if (wrEn && hit(paddr, `RTCCS_IDX_CTRL1)) begin
			ctrl1_reg[5:3] <= wd[5:3] & 3'b110;
			if (!enables_reg[`RTCCS_BIT_WAKE_ON] && wakeWriteOk_reg) begin
				ctrl1_reg[2:0] <= wd[2:0];
			end
			if (initReq_reg && setupAck_reg) begin
				ctrl1_reg[`RTCCS_BIT_FMT] <= wd[`RTCCS_BIT_FMT];
			end
		end
	end

	// enables register with reserved bits zero
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			enables_reg <= `RTCCS_RESET_BYTE;
		end else if (wrEn && hit(paddr, `RTCCS_IDX_ENABLES)) begin
			enables_reg <= wd & `RTCCS_ENABLES_MASK;
		end
	end

	// memo bit is stored; action bits are never stored
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			outputs_reg <= `RTCCS_RESET_BYTE;
			hourPlusPulse <= 1'b0;
			hourMinusPulse <= 1'b0;
		end else begin
			hourPlusPulse <= 1'b0;
			hourMinusPulse <= 1'b0;
			if (wrEn && hit(paddr, `RTCCS_IDX_OUTPUTS)) begin
				outputs_reg <= {wd[7:2], 2'b00};
				// hour adjust only outside setup mode
				hourPlusPulse <= wd[0] && !initReq_reg;
				hourMinusPulse <= wd[1] && !initReq_reg;
			end
		end
	end

	// Wake reload value, writable under the same guard as the clock choice.
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			wakeReload_reg <= `RTCCS_WAKE_RESET;
		end else if (wrEn && !enables_reg[`RTCCS_BIT_WAKE_ON] && wakeWriteOk_reg) begin
			if (hit(paddr, `RTCCS_IDX_WAKE_HI)) wakeReload_reg[15:8] <= wd;
			if (hit(paddr, `RTCCS_IDX_WAKE_LO)) wakeReload_reg[7:0] <= wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// setup request and acknowledge after a short settling delay
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			initReq_reg <= 1'b0;
			mode_reg <= RTCCS_RUN;
			setupCnt_reg <= 8'h00;
			setupAck_reg <= 1'b0;
		end else begin
			if (wrEn && hit(paddr, `RTCCS_IDX_STATUS)) initReq_reg <= wd[`RTCCS_BIT_INIT];
			unique case (mode_reg)
				RTCCS_RUN: begin
					setupAck_reg <= 1'b0;
					if (initReq_reg) begin
						mode_reg <= RTCCS_SETUP_WAIT;
						setupCnt_reg <= 8'h00;
					end
				end
				RTCCS_SETUP_WAIT: begin
					setupCnt_reg <= setupCnt_reg + 8'h01;
					if (!initReq_reg) begin
						mode_reg <= RTCCS_RUN;
					end else if (setupCnt_reg == 8'(SETUP_DELAY - 1)) begin
						mode_reg <= RTCCS_SETUP;
						setupAck_reg <= 1'b1;
					end
				end
				RTCCS_SETUP: begin
					if (!initReq_reg) begin
						mode_reg <= RTCCS_RUN;
						setupAck_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// shadow synced, set wins over software clear
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			synced_reg <= 1'b0;
		end else if (initReq_reg) begin
			synced_reg <= 1'b0;
		end else if (shadowCopied && !shadowBypass) begin
			synced_reg <= 1'b1;
		end else if (wrEn && hit(paddr, `RTCCS_IDX_STATUS) && !wd[`RTCCS_BIT_SYNC]) begin
			synced_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			shiftPend_reg <= 1'b0;
			recalPend_reg <= 1'b0;
		end else begin
			if (shiftLowWritten) shiftPend_reg <= 1'b1;
			else if (shiftDone) shiftPend_reg <= 1'b0;
			if (calibLowWritten) recalPend_reg <= 1'b1;
			else if (calibApplied) recalPend_reg <= 1'b0;
		end
	end

	// wake write allowed; alarm write allowed
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			wakeWriteOk_reg <= 1'b0;
			alarmWriteOk_reg <= 1'b0;
		end else begin
			wakeWriteOk_reg <= !enables_reg[`RTCCS_BIT_WAKE_ON] && kernelTick
				? 1'b1 : (enables_reg[`RTCCS_BIT_WAKE_ON] ? 1'b0 : wakeWriteOk_reg);
			alarmWriteOk_reg <= !enables_reg[`RTCCS_BIT_ALARM_ON];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// kernel clock divider giving /2, /4, /8, /16 enables
	logic [3:0] kdiv_reg;
	logic wakeTick;
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) kdiv_reg <= 4'h0;
		else if (kernelTick) kdiv_reg <= kdiv_reg + 4'h1;
	end
	always_comb begin
		unique case (ctrl1_reg[2:0])
			3'b000: wakeTick = kernelTick && (kdiv_reg == 4'hf);
			3'b001: wakeTick = kernelTick && (kdiv_reg[2:0] == 3'h7);
			3'b010: wakeTick = kernelTick && (kdiv_reg[1:0] == 2'h3);
			3'b011: wakeTick = kernelTick && kdiv_reg[0];
			// one-second tick for 10x and 11x
			default: wakeTick = oneHzTick;
		endcase
	end

	// reload with optional extra count; idle while off. period is reload+1.
	logic [16:0] wakeCnt_reg, reloadFull;
	logic wakeHit;
	assign reloadFull = {1'b0, wakeReload_reg} + (ctrl1_reg[2:1] == 2'b11 ? `RTCCS_EXTRA_COUNT : 17'h0);
	assign wakeHit = enables_reg[`RTCCS_BIT_WAKE_ON] && wakeTick && (wakeCnt_reg == 17'h0);
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) wakeCnt_reg <= 17'h0;
		else if (!enables_reg[`RTCCS_BIT_WAKE_ON]) wakeCnt_reg <= reloadFull;
		else if (wakeTick) wakeCnt_reg <= (wakeCnt_reg == 17'h0) ? reloadFull : wakeCnt_reg - 17'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// software zeros take effect two cycles after the write
	logic [7:0] zeroMask;
	assign zeroMask = (wrEn && hit(paddr, `RTCCS_IDX_EVENTS)) ? (~wd & `RTCCS_EVENTS_MASK) : 8'h00;
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) clrMask_reg <= 8'h00;
		else clrMask_reg <= zeroMask;
	end
	logic [7:0] clrLate_reg;
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) clrLate_reg <= 8'h00;
		else clrLate_reg <= clrMask_reg;
	end

	// event flags, a new event wins over a pending clear
	logic [7:0] setMask;
	assign setMask = {tamperEvent[2], tamperEvent[1], tamperEvent[0], 2'b00,
		wakeHit, 1'b0, alarmMatch && enables_reg[`RTCCS_BIT_ALARM_ON]};
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) events_reg <= `RTCCS_RESET_BYTE;
		else events_reg <= ((events_reg & ~clrLate_reg) | setMask) & `RTCCS_EVENTS_MASK;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux and pin outputs.
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable && !pwrite) begin
				if (hit(paddr, `RTCCS_IDX_CTRL1)) prdata[7:0] <= ctrl1_reg & `RTCCS_CTRL1_MASK;
				else if (hit(paddr, `RTCCS_IDX_ENABLES)) prdata[7:0] <= enables_reg;
				else if (hit(paddr, `RTCCS_IDX_OUTPUTS)) prdata[7:0] <= outputs_reg;
				// calendar was set from year field
				else if (hit(paddr, `RTCCS_IDX_STATUS)) prdata[7:0] <= {initReq_reg, setupAck_reg,
					synced_reg, yearField != 8'h00, shiftPend_reg, wakeWriteOk_reg,
					recalPend_reg, alarmWriteOk_reg};
				else if (hit(paddr, `RTCCS_IDX_EVENTS)) prdata[7:0] <= events_reg;
				else if (hit(paddr, `RTCCS_IDX_WAKE_HI)) prdata[7:0] <= wakeReload_reg[15:8];
				else if (hit(paddr, `RTCCS_IDX_WAKE_LO)) prdata[7:0] <= wakeReload_reg[7:0];
				else pslverr <= 1'b1;
			end else if (psel && !penable) begin
				pslverr <= !(hit(paddr, `RTCCS_IDX_CTRL1) || hit(paddr, `RTCCS_IDX_ENABLES)
					|| hit(paddr, `RTCCS_IDX_OUTPUTS) || hit(paddr, `RTCCS_IDX_STATUS)
					|| hit(paddr, `RTCCS_IDX_EVENTS) || hit(paddr, `RTCCS_IDX_WAKE_HI)
					|| hit(paddr, `RTCCS_IDX_WAKE_LO));
			end
		end
	end

	rtccs_pin_src_t pinSrc;
	logic pinFlag;
	assign pinSrc = rtccs_pin_src_t'(outputs_reg[6:5]);
	always_comb begin
		unique case (pinSrc)
			RTCCS_PIN_ALARM: pinFlag = events_reg[`RTCCS_BIT_ALARM_EVT];
			RTCCS_PIN_WAKE: pinFlag = events_reg[`RTCCS_BIT_WAKE_EVT];
			RTCCS_PIN_OFF, RTCCS_PIN_RSVD: pinFlag = 1'b0;
		endcase
	end
	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			alarmPin <= 1'b0;
			calibOutPin <= 1'b0;
			calendarStopped <= 1'b0;
			hourFormatPm <= 1'b0;
			wakeIrqEnable <= 1'b0;
			alarmIrqEnable <= 1'b0;
			alarmEnable <= 1'b0;
		end else begin
			alarmPin <= pinFlag ^ outputs_reg[4];
			calibOutPin <= outputs_reg[7] && (outputs_reg[3] ? calib1Hz : calib512Hz);
			calendarStopped <= initReq_reg;
			hourFormatPm <= ctrl1_reg[`RTCCS_BIT_FMT];
			wakeIrqEnable <= enables_reg[`RTCCS_BIT_WAKE_IRQ];
			alarmIrqEnable <= enables_reg[`RTCCS_BIT_ALARM_IRQ];
			alarmEnable <= enables_reg[`RTCCS_BIT_ALARM_ON];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// delayed flag clear
	sequence wakeZeroWrite_s;
		wrEn && hit(paddr, `RTCCS_IDX_EVENTS) && !wd[`RTCCS_BIT_WAKE_EVT];
	endsequence
	flag_clear_delay_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		wakeZeroWrite_s ##1 !wakeHit ##1 !wakeHit |=> !events_reg[`RTCCS_BIT_WAKE_EVT])
		else $error("wake flag not cleared two cycles after zero write");
	wake_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		wakeHit |=> events_reg[`RTCCS_BIT_WAKE_EVT])
		else $error("wake flag not set on counter zero");
	// counter idle while off
	// Both samples must see the timer off: the counter loads the reload value only at an edge
	// where the enable was already clear, so the first cycle after a disable still holds the old count.
	wake_idle_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		!enables_reg[`RTCCS_BIT_WAKE_ON] ##1 !enables_reg[`RTCCS_BIT_WAKE_ON]
		|-> !wakeHit && wakeCnt_reg == $past(reloadFull))
		else $error("wake counter not idle while off");
	setup_ack_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		setupAck_reg |-> initReq_reg || $past(initReq_reg))
		else $error("setup acknowledge without setup request");
	sync_clear_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		initReq_reg |=> !synced_reg)
		else $error("shadow synced not cleared in setup mode");
	shift_pend_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		shiftLowWritten |=> shiftPend_reg)
		else $error("shift pending not set");
	// idle pin level
	// An unrouted pin rests at the inactive level that the polarity bit gives it.
	pin_polarity_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		pinSrc == RTCCS_PIN_OFF && $stable(outputs_reg) |=> alarmPin == $past(outputs_reg[4]))
		else $error("alarm pin idle level wrong");
	enables_rsvd_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		(enables_reg & ~`RTCCS_ENABLES_MASK) == 8'h00)
		else $error("reserved enable bit set");
	choice_guard_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		enables_reg[`RTCCS_BIT_WAKE_ON] |=> $stable(ctrl1_reg[2:0]))
		else $error("wake clock choice changed while timer on");
endmodule
`default_nettype wire
